// file: rtl/vir_pkg.sv
// constants and types for the banked thread instruction registers
package vir_pkg;
  // ***************************************************************
  // sizes and field layout
  // ***************************************************************
  localparam int NUM_THREADS = 8;
  localparam int CODE_W      = 3;
  localparam int PF_W        = 32;
  localparam int IR_W        = 64;
  localparam int OPC_LO      = 0;
  localparam int OPC_W       = 8;
  localparam int EXEC_BIT    = 8;
  localparam int LOOK_BIT    = 9;
  localparam int LAST_BIT    = 10;
  localparam int STEP_LO     = 11;
  localparam int IND_BIT     = 14;
  localparam int MODE_BIT    = 15;
  localparam int STATE_LO    = 8;
  localparam int STATE_W     = 8;
  localparam int SRC_LO      = 16;
  localparam int DST_LO      = 24;
  localparam int SEL_W       = 8;
  localparam int FLG_LO      = 32;
  localparam int FLG_W       = 8;
  localparam int ADDR_LO     = 40;
  localparam int ADDR_W      = 24;
  localparam int BYTE_W      = 8;
  localparam int ADDR_B1_LO  = 40;
  localparam int ADDR_B2_LO  = 48;
  localparam int ADDR_B3_LO  = 56;
  // flag byte positions within bits 32-39
  localparam int F_OBJ_MODE  = 0;
  localparam int F_NEXT_LOC  = 1;
  localparam int F_BASE_MEM  = 2;
  localparam int F_REG_IND   = 3;
  localparam int F_IRQ_PEND  = 4;
  localparam int F_TRAP      = 5;
  localparam int F_PROG_IRQ  = 6;
  localparam int F_AUTO_IRQ  = 7;
  // shift increments
  localparam logic [BYTE_W-1:0] SH_INC_1  = 8'h01;
  localparam logic [BYTE_W-1:0] SH_INC_4  = 8'h04;
  localparam logic [BYTE_W-1:0] SH_INC_8  = 8'h08;
  localparam logic [BYTE_W-1:0] SH_INC_16 = 8'h10;
  localparam logic [PF_W-1:0]   PF_RST    = 32'h00000000;
  localparam logic [IR_W-1:0]   IR_RST    = 64'h0000000000000000;
  localparam logic [NUM_THREADS-1:0] ONEHOT_RST = 8'h01;
  localparam logic [CODE_W-1:0] CODE_RST  = 3'h0;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef logic [CODE_W-1:0]      vir_code_t;
  typedef logic [NUM_THREADS-1:0] vir_sel_t;
  typedef enum logic [1:0] {
    VIR_SH_1  = 2'h0,
    VIR_SH_4  = 2'h1,
    VIR_SH_8  = 2'h2,
    VIR_SH_16 = 2'h3
  } vir_shinc_t;

  // one-hot decode of a thread code, used by several selectors
  function automatic vir_sel_t vir_decode(input vir_code_t code);
    vir_sel_t s;
    s = '0;
    s[code] = 1'b1;
    return s;
  endfunction
endpackage

// file: rtl/vir_load_if.sv
// interface carrying one-hot write strobes and write data into the banks
`timescale 1ns/1ps
interface vir_load_if;
  import vir_pkg::*;
  logic [NUM_THREADS-1:0] pf_we;      // prefetch write strobe per thread
  logic [PF_W-1:0]        pf_wdata;   // prefetch write data
  logic [NUM_THREADS-1:0] ir_we;      // instruction register strobe per thread
  logic [3:0]             slice_we;   // which of the four slices load
  logic [IR_W-1:0]        ir_wdata;   // instruction register write data
  logic                   mid_we;     // second address byte joins slice 3
  modport ctl (output pf_we, pf_wdata, ir_we, slice_we, ir_wdata, mid_we);
  modport bank (input pf_we, pf_wdata, ir_we, slice_we, ir_wdata, mid_we);
endinterface

// file: rtl/vir_bank.sv
// eight prefetch and eight instruction registers with registered read ports
`timescale 1ns/1ps
module vir_bank
  import vir_pkg::*;
(
  input  wire logic            i_ref_clk,
  input  wire logic            i_rst,
  vir_load_if.bank             ld,
  input  wire vir_code_t       i_pf_rsel,   // thread driving the prefetch bus
  input  wire vir_sel_t        i_ir_rsel,   // one-hot thread on the read bus
  output logic [PF_W-1:0]      o_pf_rdata,
  output logic [IR_W-1:0]      o_ir_rdata
);
  // ***************************************************************
  // storage
  // ***************************************************************
  logic [PF_W-1:0] pf_q [NUM_THREADS];  // prefetch words
  logic [IR_W-1:0] ir_q [NUM_THREADS];  // instruction words
  logic [IR_W-1:0] mask;                 // slice write mask

  // slice boundaries are byte pairs: 0-15, 16-31, 32-47, 48-63
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      mask[s*2*BYTE_W +: 2*BYTE_W] = {(2*BYTE_W){ld.slice_we[s]}};
    end
    // a shift-only load must leave the middle address byte alone
    mask[ADDR_B2_LO +: BYTE_W] = {BYTE_W{ld.slice_we[3] & ld.mid_we}};
  end

  for (genvar t = 0; t < NUM_THREADS; t++) begin : g_thr
    // only the strobed thread changes; the rest hold
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        pf_q[t] <= PF_RST;
      end else if (ld.pf_we[t]) begin
        pf_q[t] <= ld.pf_wdata;
      end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        ir_q[t] <= IR_RST;
      end else if (ld.ir_we[t]) begin
        ir_q[t] <= (ir_q[t] & ~mask) | (ld.ir_wdata & mask);
      end
    end
  end

  // registered read ports
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pf_rdata <= PF_RST;
    end else begin
      o_pf_rdata <= pf_q[i_pf_rsel];
    end
  end

  // read bus takes the highest-numbered selected register, else zero; the select is one-hot
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ir_rdata <= IR_RST;
    end else begin
      o_ir_rdata <= IR_RST;
      for (int t = 0; t < NUM_THREADS; t++) begin
        if (i_ir_rsel[t]) begin
          o_ir_rdata <= ir_q[t];
        end
      end
    end
  end
endmodule

// file: rtl/vir_shift_sel.sv
// shift increment encoder for the third effective-address byte
`timescale 1ns/1ps
module vir_shift_sel
  import vir_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  input  wire vir_shinc_t         i_inc,
  output logic [BYTE_W-1:0]       o_inc_byte
);
  // registered so the write data path has one clean stage
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_inc_byte <= SH_INC_1;
    end else begin
      case (i_inc)
        VIR_SH_1:  o_inc_byte <= SH_INC_1;
        VIR_SH_4:  o_inc_byte <= SH_INC_4;
        VIR_SH_8:  o_inc_byte <= SH_INC_8;
        VIR_SH_16: o_inc_byte <= SH_INC_16;
        default:   o_inc_byte <= SH_INC_1;
      endcase
    end
  end
endmodule

// file: rtl/vir_instr_regs.sv
// banked prefetch and instruction registers for eight threads, top level
`timescale 1ns/1ps
module vir_instr_regs
  import vir_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_rst,
  // prefetch loading
  input  wire logic               i_prefetch_load_enable,
  input  wire logic               i_rom_to_prefetch_gate,
  input  wire logic               i_word_buffer_use,
  input  wire logic [PF_W-1:0]    i_rom_data,
  input  wire logic [PF_W-1:0]    i_word_buffer_data,
  input  wire vir_code_t          i_active_thread_code_a,
  input  wire vir_code_t          i_active_thread_code_b,
  input  wire vir_code_t          i_next_thread_code,
  // end-of-cycle instruction register load
  input  wire logic               i_cycle_end,
  input  wire logic               i_test_positive,
  input  wire logic [OPC_W-1:0]   i_pipe_opcode,
  input  wire logic [OPC_W-1:0]   i_normal_opcode,
  input  wire logic [STATE_W-1:0] i_test_variant_bits,
  input  wire logic [STATE_W-1:0] i_normal_variant_bits,
  input  wire logic [FLG_W-1:0]   i_test_variant_flags,
  input  wire logic [FLG_W-1:0]   i_normal_variant_flags,
  input  wire logic               i_src_from_register_indexer,
  input  wire logic               i_dst_from_register_indexer,
  input  wire logic [SEL_W-1:0]   i_operand_src_sel,
  input  wire logic [SEL_W-1:0]   i_operand_dst_sel,
  input  wire logic [SEL_W-1:0]   i_register_src_sel,
  input  wire logic [SEL_W-1:0]   i_register_dst_sel,
  input  wire logic [ADDR_W-1:0]  i_operand_addr,
  input  wire logic               i_addr_load_enable,
  input  wire logic               i_shift_update,
  input  wire vir_shinc_t         i_shift_inc,
  // flag-setting events
  input  wire logic               i_base_in_memory,
  input  wire logic               i_indirect_via_register,
  input  wire logic               i_program_irq,
  input  wire logic               i_auto_irq_event,
  input  wire logic               i_last_step,
  // outputs
  output logic [PF_W-1:0]         o_prefetch_bus,
  output logic [IR_W-1:0]         o_instr_read_bus,
  output vir_code_t               o_active_thread_q
);
  // ***************************************************************
  // thread selection
  // ***************************************************************
  vir_code_t         code_q;        // captured active-thread code
  vir_sel_t          next_sel_q;    // one-hot next-thread read select
  vir_sel_t          act_sel;       // decode of captured code
  vir_sel_t          pf_sel;        // decode for prefetch writes
  logic [BYTE_W-1:0] inc_byte;      // registered shift increment
  logic              shift_q;       // shift update aligned to inc_byte
  logic [IR_W-1:0]   wdata;         // assembled write word
  logic [3:0]        slice_we;      // per-slice loads
  logic [FLG_W-1:0]  flags;         // flag byte before event merges
  vir_sel_t          irq_seen_q;    // any interrupt seen, per thread
  // per-thread memories: an interrupt may come in a cycle that does
  // not load the register, and it must not be lost
  logic              prog_seen_q [NUM_THREADS]; // programmed events
  logic              auto_seen_q [NUM_THREADS]; // automatic events

  vir_load_if ld();

  // three flops latch the code every cycle
  // the code used for loads is therefore one cycle old
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      code_q <= CODE_RST;
    end else begin
      code_q <= i_active_thread_code_b;
    end
  end

  // next-thread code is decoded into eight one-hot flops at cycle end
  // reset points at thread zero so the read bus is always defined
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      next_sel_q <= ONEHOT_RST;
    end else if (i_cycle_end) begin
      next_sel_q <= vir_decode(i_next_thread_code);
    end
  end

  // captured code picks the register to load,
  // code a picks the prefetch word to write
  always_comb begin
    act_sel = vir_decode(code_q);
    pf_sel  = vir_decode(i_active_thread_code_a);
  end

  // already a flop, so the port is clean
  assign o_active_thread_q = code_q;

  // ***************************************************************
  // prefetch write path
  // ***************************************************************
  // word buffer data takes priority: it replaces rom data when in use
  always_comb begin
    ld.pf_we    = '0;
    ld.pf_wdata = i_rom_data;
    if (i_word_buffer_use) begin
      ld.pf_wdata = i_word_buffer_data;
    end
    // a load needs the enable and a live source
    if (i_prefetch_load_enable && (i_rom_to_prefetch_gate || i_word_buffer_use)) begin
      ld.pf_we = pf_sel;
    end
  end

  // ***************************************************************
  // shift increment stage
  // ***************************************************************
  // increment is encoded one stage ahead of the load
  vir_shift_sel u_shift (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_inc      (i_shift_inc),
    .o_inc_byte (inc_byte)
  );

  // delay the update request to meet the registered increment
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_q <= 1'b0;
    end else begin
      shift_q <= i_shift_update;
    end
  end

  // ***************************************************************
  // interrupt bookkeeping per thread
  // ***************************************************************
  // a thread remembers that an interrupt occurred during its instruction
  // so the pending flag can be raised at its last step; cleared then
  for (genvar t = 0; t < NUM_THREADS; t++) begin : g_irq
    // programmed interrupt memory
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        prog_seen_q[t] <= 1'b0;
      end else if (act_sel[t] && i_program_irq) begin
        prog_seen_q[t] <= 1'b1; // set wins over clear
      end else if (act_sel[t] && i_cycle_end && i_last_step) begin
        prog_seen_q[t] <= 1'b0; // honoured at the last step
      end
    end
    // automatic interrupt memory, same life cycle
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        auto_seen_q[t] <= 1'b0;
      end else if (act_sel[t] && i_auto_irq_event) begin
        auto_seen_q[t] <= 1'b1; // set wins over clear
      end else if (act_sel[t] && i_cycle_end && i_last_step) begin
        auto_seen_q[t] <= 1'b0;
      end
    end
    assign irq_seen_q[t] = prog_seen_q[t] | auto_seen_q[t];
  end

  // ***************************************************************
  // instruction register write word
  // ***************************************************************
  // write word and slice strobes for the captured thread
  always_comb begin
    wdata    = IR_RST;
    slice_we = '0;
    flags    = i_test_positive ? i_test_variant_flags : i_normal_variant_flags;
    // indexing events only count when the step goes on
    if (!i_test_positive) begin
      flags[F_BASE_MEM] = flags[F_BASE_MEM] | i_base_in_memory;
      flags[F_REG_IND]  = flags[F_REG_IND] | i_indirect_via_register;
    end
    // remembered events count as well as those of this cycle
    flags[F_PROG_IRQ] = flags[F_PROG_IRQ] | prog_seen_q[code_q] | i_program_irq;
    flags[F_AUTO_IRQ] = flags[F_AUTO_IRQ] | auto_seen_q[code_q] | i_auto_irq_event;
    // pending flag at the last step of an interrupted instruction
    if (i_last_step && (irq_seen_q[code_q] || i_program_irq || i_auto_irq_event)) begin
      flags[F_IRQ_PEND] = 1'b1;
    end

    // slice 0: opcode and state byte
    if (i_test_positive) begin
      wdata[OPC_LO +: OPC_W]     = i_pipe_opcode;
      wdata[STATE_LO +: STATE_W] = i_test_variant_bits;
    end else begin
      wdata[OPC_LO +: OPC_W]     = i_normal_opcode;
      wdata[STATE_LO +: STATE_W] = i_normal_variant_bits;
    end

    // slice 1: selectors, chosen per field
    wdata[SRC_LO +: SEL_W] = i_src_from_register_indexer ? i_register_src_sel : i_operand_src_sel;
    wdata[DST_LO +: SEL_W] = i_dst_from_register_indexer ? i_register_dst_sel : i_operand_dst_sel;

    // slices 2 and 3: flags and effective address
    wdata[FLG_LO +: FLG_W]   = flags;
    wdata[ADDR_LO +: ADDR_W] = i_operand_addr;
    // a shift count update overrides the third address byte
    if (shift_q) begin
      wdata[ADDR_B3_LO +: BYTE_W] = inc_byte;
    end

    // strobes are held off until the cycle ends
    if (i_cycle_end) begin
      slice_we[0] = 1'b1;
      slice_we[1] = !i_test_positive;
      slice_we[2] = 1'b1;
      slice_we[3] = (!i_test_positive && i_addr_load_enable) || shift_q;
    end
    // hand over to the banks
    ld.ir_we    = i_cycle_end ? act_sel : '0;
    ld.slice_we = slice_we;
    ld.mid_we   = !i_test_positive && i_addr_load_enable;
    ld.ir_wdata = wdata;
  end

  // ***************************************************************
  // banks
  // ***************************************************************
  // the address byte one of slice 2 is loaded with the flags; when the
  // address is not to load, callers hold i_operand_addr steady
  vir_bank u_bank (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .ld         (ld.bank),
    .i_pf_rsel  (code_q),
    .i_ir_rsel  (next_sel_q),
    .o_pf_rdata (o_prefetch_bus),
    .o_ir_rdata (o_instr_read_bus)
  );

  // ***************************************************************
  // checks
  // ***************************************************************
  // a prefetch write lands on the pointed thread only
  a_pf_other_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (ld.pf_we & ~pf_sel) == '0) else $error("prefetch write hit wrong thread");

  // no prefetch write without the load enable
  a_pf_no_load: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_prefetch_load_enable |-> ld.pf_we == '0) else $error("prefetch written while idle");

  // buffer word replaces rom data
  a_pf_wb_src: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_word_buffer_use |-> ld.pf_wdata == i_word_buffer_data) else $error("buffer data not routed");

  // the code flops follow the sequencer every cycle
  a_code_capture: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    1'b1 |=> code_q == $past(i_active_thread_code_b)) else $error("thread code not captured");

  // selectors keep their value on a taken test
  a_sel_no_test: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_test_positive |-> !slice_we[1]) else $error("selectors loaded on taken test");

  // source selector follows its indexer choice
  a_src_pick: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_src_from_register_indexer |-> wdata[SRC_LO +: SEL_W] == i_register_src_sel)
    else $error("source selector wrong");

  // opcode and state byte follow the test outcome
  a_opc_test: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_test_positive |-> wdata[OPC_LO +: OPC_W] == i_pipe_opcode) else $error("wrong opcode on test");
  a_opc_normal: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_test_positive |-> wdata[OPC_LO +: OPC_W] == i_normal_opcode) else $error("wrong normal opcode");
  a_state_test: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_test_positive |-> wdata[STATE_LO +: STATE_W] == i_test_variant_bits)
    else $error("wrong test state bits");
  a_state_normal: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_test_positive |-> wdata[STATE_LO +: STATE_W] == i_normal_variant_bits)
    else $error("wrong normal state bits");

  // read select is one-hot and follows the next-thread code
  a_onehot_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $onehot(next_sel_q)) else $error("read select not one-hot");
  a_read_sel: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cycle_end |=> next_sel_q == vir_decode($past(i_next_thread_code)))
    else $error("read select not updated");

  // only the captured thread is strobed, and only at cycle end
  a_ir_we_active: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cycle_end |-> ld.ir_we == act_sel) else $error("wrong thread loaded");
  a_ir_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_cycle_end |-> ld.ir_we == '0) else $error("register loaded mid-cycle");

  // shift increment lands one cycle after the request
  a_shift_byte: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_shift_update && i_shift_inc == VIR_SH_16 |=> wdata[ADDR_B3_LO +: BYTE_W] == SH_INC_16)
    else $error("shift increment not inserted");

  // middle address byte never loads on a taken test
  a_mid_no_test: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_test_positive |-> !ld.mid_we) else $error("address loaded on taken test");

  // flag byte: variant choice plus merged events
  a_flags_var: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_test_positive |-> wdata[FLG_LO + F_OBJ_MODE] == i_normal_variant_flags[F_OBJ_MODE])
    else $error("object mode bit wrong");
  a_base_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_test_positive && i_base_in_memory |-> wdata[FLG_LO + F_BASE_MEM])
    else $error("base flag not set");
  a_prog_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_program_irq |-> wdata[FLG_LO + F_PROG_IRQ]) else $error("programmed flag not set");
  a_auto_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_auto_irq_event |-> wdata[FLG_LO + F_AUTO_IRQ]) else $error("automatic flag not set");
  a_pend_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_last_step && i_auto_irq_event |-> wdata[FLG_LO + F_IRQ_PEND])
    else $error("pending flag not set");
endmodule

// file: test/vir_seq_model.sv
// thread sequencer model: drives the thread codes and the end-of-cycle strobe
`timescale 1ns/1ps
module vir_seq_model
  import vir_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_slow,
  output vir_code_t o_code_a,
  output vir_code_t o_code_b,
  output vir_code_t o_next_code,
  output logic      o_cycle_end
);
  // ***************************************************************
  // thread scheduling
  // ***************************************************************
  // codes change just after each edge; slow mode stretches cycles so
  // loads land on irregular edges instead of every clock
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_code_a    <= CODE_RST;
      o_code_b    <= CODE_RST;
      o_next_code <= CODE_RST;
      o_cycle_end <= 1'b0;
    end else begin
      o_code_a    <= vir_code_t'($urandom);
      o_code_b    <= vir_code_t'($urandom);
      o_next_code <= vir_code_t'($urandom);
      o_cycle_end <= i_slow ? ($urandom % 3 == 0) : 1'b1;
    end
  end
endmodule

// file: test/tb_vir_instr_regs.sv
// self-checking bench for the banked thread instruction registers
`timescale 1ns/1ps
module tb_vir_instr_regs;
  import vir_pkg::*;
  // ***************************************************************
  // stimulus and design signals
  // ***************************************************************
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic slow = 1'b0;
  logic tp_hi = 1'b0;
  logic ple = 0, gate = 0, wbu = 0, tp = 0, sfr = 0, dfr = 0, ale = 0, shu = 0;
  logic bim = 0, ivr = 0, prq = 0, arq = 0, lst = 0, ce;
  logic [31:0] rom = 0, wbd = 0;
  logic [7:0] pop = 0, nop = 0, tvb = 0, nvb = 0, tfl = 0, nfl = 0, os = 0, od = 0, rs = 0, rd = 0;
  logic [23:0] addr = 0;
  vir_shinc_t inc = VIR_SH_1;
  vir_code_t ca, cb, nc, o_active_thread_q;
  logic [31:0] o_prefetch_bus;
  logic [63:0] o_instr_read_bus;
  int n_mismatch = 0;
  int total_checks = 0;

  always #25 i_ref_clk = ~i_ref_clk;   // 20 MHz

  vir_seq_model SEQ (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_slow(slow), .o_code_a(ca),
    .o_code_b(cb), .o_next_code(nc), .o_cycle_end(ce));

  vir_instr_regs DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_prefetch_load_enable(ple),
    .i_rom_to_prefetch_gate(gate), .i_word_buffer_use(wbu), .i_rom_data(rom), .i_word_buffer_data(wbd),
    .i_active_thread_code_a(ca), .i_active_thread_code_b(cb), .i_next_thread_code(nc), .i_cycle_end(ce),
    .i_test_positive(tp), .i_pipe_opcode(pop), .i_normal_opcode(nop), .i_test_variant_bits(tvb),
    .i_normal_variant_bits(nvb), .i_test_variant_flags(tfl), .i_normal_variant_flags(nfl),
    .i_src_from_register_indexer(sfr), .i_dst_from_register_indexer(dfr), .i_operand_src_sel(os),
    .i_operand_dst_sel(od), .i_register_src_sel(rs), .i_register_dst_sel(rd), .i_operand_addr(addr),
    .i_addr_load_enable(ale), .i_shift_update(shu), .i_shift_inc(inc), .i_base_in_memory(bim),
    .i_indirect_via_register(ivr), .i_program_irq(prq), .i_auto_irq_event(arq), .i_last_step(lst),
    .o_prefetch_bus(o_prefetch_bus), .o_instr_read_bus(o_instr_read_bus), .o_active_thread_q(o_active_thread_q));

  // ***************************************************************
  // random data drive, just after each rising edge
  // ***************************************************************
  // rare word-buffer use and rare shifts keep both paths visible without drowning the others
  always @(posedge i_ref_clk) begin
    {ple, gate, sfr, dfr, ale, bim, ivr} <= 7'($urandom);
    wbu <= ($urandom % 3 == 0);
    shu <= ($urandom % 4 == 0);
    prq <= ($urandom % 8 == 0);
    arq <= ($urandom % 8 == 0);
    lst <= ($urandom % 3 == 0);
    tp <= tp_hi ? ($urandom % 4 != 0) : ($urandom % 4 == 0);
    {rom, wbd} <= {$urandom, $urandom};
    {pop, nop, tvb, nvb} <= $urandom;
    {tfl, nfl, os, od} <= $urandom;
    {rs, rd} <= 16'($urandom);
    addr <= 24'($urandom);
    inc <= vir_shinc_t'($urandom);
  end

  // ***************************************************************
  // reference model, integers and arrays only
  // ***************************************************************
  logic [31:0] m_pf[8];
  logic [63:0] m_ir[8];
  logic [7:0] m_nsel, m_incq, m_mp, m_ma;
  logic [31:0] m_pfb;
  logic [63:0] m_irb;
  logic [2:0] m_cq;
  logic m_shq;
  // outputs come from the state before this edge, then the state updates
  always @(posedge i_ref_clk or posedge i_rst) begin
    logic [63:0] w;
    logic [7:0] f;
    logic mp, ma;
    int t;
    if (i_rst) begin
      for (int i = 0; i < 8; i++) begin
        m_pf[i] = '0;
        m_ir[i] = '0;
      end
      {m_pfb, m_irb, m_cq, m_shq, m_incq, m_mp, m_ma} = '0;
      m_nsel = 8'h01;
    end else begin
      m_pfb = m_pf[m_cq];
      m_irb = '0;
      for (int i = 0; i < 8; i++) if (m_nsel[i]) m_irb = m_ir[i];
      if (ple && (gate || wbu)) m_pf[ca] = wbu ? wbd : rom;
      t = m_cq;
      mp = m_mp[t] | prq;
      ma = m_ma[t] | arq;
      if (ce) begin
        w = m_ir[t];
        w[15:0] = tp ? {tvb, pop} : {nvb, nop};
        if (!tp) w[31:16] = {dfr ? rd : od, sfr ? rs : os};
        f = tp ? tfl : nfl;
        if (!tp) f[3:2] = f[3:2] | {ivr, bim};
        f[6] = f[6] | mp;
        f[7] = f[7] | ma;
        if (lst && (mp || ma)) f[4] = 1'b1;
        w[47:32] = {addr[7:0], f};
        if (!tp && ale) w[63:48] = addr[23:8];
        if (m_shq) w[63:56] = m_incq;
        m_ir[t] = w;
        if (lst) begin
          mp = prq;
          ma = arq;
        end
        m_nsel = 8'h01 << nc;
      end
      m_mp[t] = mp;
      m_ma[t] = ma;
      m_shq = shu;
      case (inc)
        VIR_SH_1: m_incq = SH_INC_1;
        VIR_SH_4: m_incq = SH_INC_4;
        VIR_SH_8: m_incq = SH_INC_8;
        default:  m_incq = SH_INC_16;
      endcase
      m_cq = cb;
    end
  end

  // ***************************************************************
  // comparison and verdict
  // ***************************************************************
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // outputs are settled half a period after the edge
  always @(negedge i_ref_clk) begin
    chk(64'(o_prefetch_bus), 64'(m_pfb));
    chk(o_instr_read_bus, m_irb);
    chk(64'(o_active_thread_q), 64'(m_cq));
  end

  // a hang is cut short and counted as a mismatch
  initial begin
    #5000000;
    n_mismatch++;
    print_verdict();
  end

  // ***************************************************************
  // main sequence: fast/slow cycles, test-positive mostly off/on
  // ***************************************************************
  initial begin
    void'($urandom(32'hb88c));
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int ph = 0; ph < 4; ph++) begin
      slow <= ph[0];
      tp_hi <= ph[1];
      repeat (500) @(posedge i_ref_clk);
    end
    // second reset in mid-run clears every bank
    i_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (300) @(posedge i_ref_clk);
    print_verdict();
  end
endmodule
